// *** core/windowed_watchdog_timer.v ***
// Purpose: windowed watchdog with APB registers and interrupt
// Assumes: LOW_POWER_RC_OSC arrives as an asynchronous pin; CPU events are pclk pulses
// Notes: device reset request is a registered pulse output
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module windowed_watchdog_timer #(
   parameter CFG_INIT = `CFG_RESET
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire low_power_rc_osc,
   input wire clear_watchdog_instr,
   input wire sleep_enter,
   input wire idle_enter,
   input wire power_save_exit,
   input wire clock_switch_done,
   output reg low_power_rc_osc_enable,
   output reg wake_req,
   output reg device_reset_req,
   output reg irq
);
   // Register map, byte offsets on the word-wide bus
   //   CONFIG  0x000  [3:0] postscale_ratio, [4] prescale_select (1 selects /128),
   //                  [6] window_disable, [8:7] watchdog_enable_mode
   //   CONTROL 0x004  reset_control_reg: [2] idle, [3] sleep, [4] timeout_flag,
   //                  [5] soft_watchdog_enable; hardware sets win over writes
   //   STATUS  0x008  read only: [0] run time-out, [1] wake time-out, [2] early clear
   //   IRQ_EN  0x00C  interrupt enables, same layout as STATUS
   //   IRQ_CLR 0x010  write one to clear STATUS bits, reads zero
   //   COUNT   0x014  read only postscaler count, handy for placing a windowed clear
   // Unmapped offsets read zero, ignore writes and answer with pslverr
   // Every transfer is answered with zero wait states
   reg [8:0] cfg_r;
   reg [5:2] reset_control_reg_r;
   reg sleeping_r;
   reg idling_r;
   reg [15:0] post_r;
   reg [2:0] irq_sts_r;
   reg [2:0] irq_en_r;
   reg osc_d_r;
   reg [3:0] rst_cnt_r;
   wire osc_s;
   wire pre_tick;
   wire [3:0] ps = cfg_r[`CFG_PS_MSB:`CFG_PS_LSB];
   wire [1:0] en_mode = cfg_r[`CFG_EN_MSB:`CFG_EN_LSB];
   wire windowed = ~cfg_r[`CFG_WINDOW_DISABLE_BIT];
   // Time-out length in oscillator rising edges is prescale times 2^postscale_ratio
   // Limitation: the oscillator is sampled by pclk, so it must stay well below pclk/4
   // Window opens once the count reaches last - last/4; ratio 1:1 has no closed part
   wire [15:0] post_last = (16'h0001 << ps) - 16'h0001;
   wire [15:0] win_start = post_last - (post_last >> 2);

   // Enable decode per configuration mode
   reg wdt_on;
   always @* begin
      case (en_mode)
         `EN_ALWAYS: begin
            wdt_on = 1'b1;
         end
         `EN_SOFT: begin
            wdt_on = reset_control_reg_r[`RC_SWEN_BIT];
         end
         `EN_RUN_IDLE: begin
            wdt_on = ~sleeping_r;
         end
         default: begin
            wdt_on = 1'b0;
         end
      endcase
   end

   // LOW_POWER_RC_OSC edge detect on the filtered copy only
   // The pin is asynchronous; only the agreed synchroniser output is used here,
   // so a glitch shorter than one pclk cycle never reaches the prescaler
   wdt_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .d(low_power_rc_osc),
      .q(osc_s)
   );
   wire osc_rise = osc_s & ~osc_d_r;

   // Early clear inside windowed mode counts as a violation
   // Clears during sleep or idle are never early, the core is not executing then
   wire early_clr = clear_watchdog_instr & wdt_on & windowed & ~sleeping_r & ~idling_r &
      (post_r < win_start);

   // Clear sources kept apart so each can be probed on its own
   wire save_clr = sleep_enter | idle_enter | power_save_exit;
   wire switch_clr = clock_switch_done;
   wire instr_clr = clear_watchdog_instr & ~early_clr;

   // Any of these restarts the whole count chain
   // A disabled watchdog is held cleared, so it starts from zero when enabled
   wire cnt_clr = ~wdt_on | save_clr | switch_clr | instr_clr;

   wdt_prescaler #(.W(7)) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .clr(cnt_clr | early_clr),
      .tick_in(osc_rise & wdt_on),
      .long_sel(cfg_r[`CFG_PRESCALE_BIT]),
      .tick_out(pre_tick)
   );

   wire expire = pre_tick & wdt_on & (post_r >= post_last);
   wire in_save = sleeping_r | idling_r;
   wire wake_evt = expire & in_save;
   wire rst_evt = (expire & ~in_save) | early_clr;

   // APB decode; zero wait states
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_cfg = (paddr == `OFS_CONFIG);
   wire hit_ctl = (paddr == `OFS_CONTROL);
   wire hit_sts = (paddr == `OFS_STATUS);
   wire hit_ien = (paddr == `OFS_IRQ_EN);
   wire hit_clr = (paddr == `OFS_IRQ_CLR);
   wire hit_cnt = (paddr == `OFS_COUNT);
   wire known = hit_cfg | hit_ctl | hit_sts | hit_ien | hit_clr | hit_cnt;
   wire w_ctl = wr & hit_ctl;
   wire w_clr = wr & hit_clr;

   reg [31:0] rd_nxt;
   always @* begin
      case (paddr)
         `OFS_CONFIG: begin
            rd_nxt = {23'h000000, cfg_r};
         end
         `OFS_CONTROL: begin
            rd_nxt = {26'h0000000, reset_control_reg_r, 2'h0};
         end
         `OFS_STATUS: begin
            rd_nxt = {29'h00000000, irq_sts_r};
         end
         `OFS_IRQ_EN: begin
            rd_nxt = {29'h00000000, irq_en_r};
         end
         `OFS_COUNT: begin
            rd_nxt = {16'h0000, post_r};
         end
         default: begin
            rd_nxt = 32'h00000000; // Clear register and holes read zero
         end
      endcase
   end

   // Bus answer registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~known;
         prdata <= rd_nxt;
      end
   end

   // Postscaler count and oscillator edge history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_r <= 16'h0000;
         osc_d_r <= 1'b0;
      end else if (clk_en) begin
         osc_d_r <= osc_s;
         if (cnt_clr | rst_evt | wake_evt) begin
            post_r <= 16'h0000;
         end else if (pre_tick & wdt_on) begin
            post_r <= post_r + 16'h0001;
         end
      end
   end

   // Configuration word; reset loads the programmed defaults at once,
   // so a later write of zero really selects the disabled mode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= CFG_INIT[8:0];
      end else if (clk_en) begin
         if (wr & hit_cfg) begin
            cfg_r <= pwdata[8:0];
         end
      end
   end

   // Reset-control bits: hardware set wins over software write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_control_reg_r <= 4'h0;
         sleeping_r <= 1'b0;
         idling_r <= 1'b0;
      end else if (clk_en) begin
         if (w_ctl) begin
            reset_control_reg_r <= pwdata[5:2];
         end
         if (en_mode == `EN_RUN_IDLE & w_ctl) begin
            reset_control_reg_r[`RC_SWEN_BIT] <= 1'b0;
         end
         if (sleep_enter) begin
            reset_control_reg_r[`RC_SLEEP_BIT] <= 1'b1;
            sleeping_r <= 1'b1;
         end
         if (idle_enter) begin
            reset_control_reg_r[`RC_IDLE_BIT] <= 1'b1;
            idling_r <= 1'b1;
         end
         if (power_save_exit | wake_evt) begin
            sleeping_r <= 1'b0;
            idling_r <= 1'b0;
         end
         if (rst_evt | wake_evt) begin
            reset_control_reg_r[`RC_TIMEOUT_BIT] <= 1'b1;
         end
      end
   end

   // Oscillator enable and wake pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_rc_osc_enable <= 1'b0;
         wake_req <= 1'b0;
      end else if (clk_en) begin
         low_power_rc_osc_enable <= wdt_on;
         wake_req <= wake_evt;
      end
   end

   // Reset request stretch
   // The request rises in the cycle after the event and is held for the
   // pulse length, long enough for a slow reset controller to see it.
   // Trade-off: a second event inside the stretch restarts the count
   // rather than queueing a second reset.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         device_reset_req <= 1'b0;
         rst_cnt_r <= 4'h0;
      end else if (clk_en) begin
         if (rst_evt) begin
            rst_cnt_r <= `DEV_RESET_PULSE;
         end else if (rst_cnt_r != 4'h0) begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
         end
         device_reset_req <= rst_evt | (rst_cnt_r > 4'h1);
      end
   end

   // Interrupt enable, sticky status and level output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_r <= 3'h0;
         irq_en_r <= 3'h0;
         irq <= 1'b0;
      end else if (clk_en) begin
         if (wr & hit_ien) begin
            irq_en_r <= pwdata[2:0];
         end
         // Set beats a same-cycle clear
         irq_sts_r <= (irq_sts_r & ~({3{w_clr}} & pwdata[2:0])) |
            {early_clr, wake_evt, expire & ~in_save};
         irq <= |(irq_sts_r & irq_en_r);
      end
   end
endmodule // windowed_watchdog_timer
`default_nettype wire

// *** core/wdt_defines.vh ***
// Purpose: shared constants for the windowed watchdog timer
// Assumes: included by bare name from core design files
// Notes: register offsets are byte addresses on a 32-bit APB
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Register byte offsets
`define OFS_CONFIG 12'h000
`define OFS_CONTROL 12'h004
`define OFS_STATUS 12'h008
`define OFS_IRQ_EN 12'h00C
`define OFS_IRQ_CLR 12'h010
`define OFS_COUNT 12'h014

// Config word fields
`define CFG_PS_LSB 0
`define CFG_PS_MSB 3
`define CFG_PRESCALE_BIT 4
`define CFG_WINDOW_DISABLE_BIT 6
`define CFG_EN_LSB 7
`define CFG_EN_MSB 8
`define CFG_RESET 9'h1CF

// Reset-control register fields
`define RC_IDLE_BIT 2
`define RC_SLEEP_BIT 3
`define RC_TIMEOUT_BIT 4
`define RC_SWEN_BIT 5

// Enable field encodings
`define EN_OFF 2'h0
`define EN_RUN_IDLE 2'h1
`define EN_SOFT 2'h2
`define EN_ALWAYS 2'h3

// Timing
`define LOW_POWER_RC_OSC_HZ 31000
`define SYS_HZ 200000000
`define PRE_SHORT 32
`define PRE_LONG 128
`define DEV_RESET_PULSE 4'h8

`endif

// *** core/wdt_sync.v ***
// Purpose: three-flop synchroniser with agreement filter
// Assumes: d comes from outside the pclk domain
// Notes: change accepted once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module wdt_sync (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire d,
   output reg q
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // First stage feeds only the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q <= s3_r;
         end
      end
   end
endmodule // wdt_sync
`default_nettype wire

// *** core/wdt_prescaler.v ***
// Purpose: LOW_POWER_RC_OSC tick prescaler, divide by 32 or 128
// Assumes: tick_in is a one-cycle pulse per LOW_POWER_RC_OSC edge
// Notes: clear has priority over counting
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module wdt_prescaler #(
   parameter W = 7
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire clr,
   input wire tick_in,
   input wire long_sel,
   output reg tick_out
);
   reg [W-1:0] cnt_r;
   localparam integer LAST_LONG = `PRE_LONG - 1;
   localparam integer LAST_SHORT = `PRE_SHORT - 1;
   // Full-width copies, cut on purpose to the counter width
   wire [31:0] last_long_w = LAST_LONG;
   wire [31:0] last_short_w = LAST_SHORT;
   wire [W-1:0] last = long_sel ? last_long_w[W-1:0] : last_short_w[W-1:0];
   // Terminal count per selected width
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= {W{1'b0}};
         tick_out <= 1'b0;
      end else if (ce) begin
         tick_out <= 1'b0;
         if (clr) begin
            cnt_r <= {W{1'b0}};
         end else if (tick_in) begin
            if (cnt_r >= last) begin
               cnt_r <= {W{1'b0}};
               tick_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule // wdt_prescaler
`default_nettype wire

// *** sim/wdt_chk.sv ***
// Purpose: port checker for the windowed watchdog
// Assumes: zero-wait APB slave, registered outputs
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module wdt_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic low_power_rc_osc_enable,
   input wire logic wake_req,
   input wire logic device_reset_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup cycles, any and unmapped
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bad;
      psel && !penable && paddr > 12'h014;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready) else $error("pready missing");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_unmapped_err: assert property (s_bad |=> pslverr) else $error("unmapped not refused");
   a_mapped_ok: assert property (s_setup and paddr[1:0] == 2'h0 && paddr <= 12'h014 |=> !pslverr)
      else $error("mapped refused");
   a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake not a pulse");
   a_wake_enabled: assert property ($rose(wake_req) |-> $past(low_power_rc_osc_enable)) else $error("wake off");
   a_reset_hold: assert property ($rose(device_reset_req) |-> device_reset_req[*4])
      else $error("reset pulse short");
   a_one_event: assert property (!(wake_req && $rose(device_reset_req))) else $error("wake and reset");
endmodule // wdt_chk
bind windowed_watchdog_timer wdt_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .low_power_rc_osc_enable(low_power_rc_osc_enable), .wake_req(wake_req),
   .device_reset_req(device_reset_req));
`default_nettype wire

// *** sim/windowed_watchdog_timer_bench.sv ***
// Purpose: self-checking bench for the windowed watchdog
// Assumes: zero-wait APB, event inputs are pclk pulses
// Notes: oscillator edge every 4 pclk cycles, only while running
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module windowed_watchdog_timer_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, low_power_rc_osc_run = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, lfsr = 32'h9742;
   logic pready, pslverr, low_power_rc_osc_enable, wake_req, device_reset_req, irq;
   logic [4:0] ev = 0;
   logic [64:0] q[$];
   logic [64:0] e;
   int n_mismatch = 0, samples_checked = 0, n_rst = 0, n_wake = 0, cyc = 0, lc = 0;
   windowed_watchdog_timer dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_power_rc_osc(osc), .clear_watchdog_instr(ev[0]), .sleep_enter(ev[1]),
      .idle_enter(ev[2]), .power_save_exit(ev[3]), .clock_switch_done(ev[4]), .low_power_rc_osc_enable(low_power_rc_osc_enable),
      .wake_req(wake_req), .device_reset_req(device_reset_req), .irq(irq));
   // Clock
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Read expectations are queued as {err, mask, value}
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, m, x, input logic err);
      if (!w) q.push_back({err, m, x});
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do begin
         @(posedge pclk);
      end while (!pready);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic pulse(input int i);
      ev <= 5'h01 << i;
      @(posedge pclk) ev <= 5'h00;
      @(posedge pclk);
   endtask
   // Slow oscillator: one rising edge per 8 pclk cycles
   task automatic edges(input int n);
      low_power_rc_osc_run <= 1;
      repeat (n * 8) @(posedge pclk);
      low_power_rc_osc_run <= 0;
      wt(8);
   endtask
   // Oscillator pin, read monitor and hang limit
   always @(posedge pclk) begin
      lc <= (lc + 1) % 4;
      if (lc == 3 && low_power_rc_osc_run) osc <= ~osc;
      cyc <= cyc + 1;
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[64]});
         chk(prdata & e[63:32], e[31:0]);
      end
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   // Count event pulses
   always @(posedge device_reset_req) n_rst++;
   always @(posedge wake_req) n_wake++;
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      apb(0, `OFS_CONFIG, 0, 32'h1FF, `CFG_RESET, 0);
      apb(0, `OFS_CONTROL, 0, 32'h3C, 0, 0);
      lfsr = nxt(lfsr);
      apb(1, 12'h020, lfsr, 0, 0, 0);
      apb(0, 12'h020, 0, 32'hFFFFFFFF, 0, 1);
      $display("test registers done");
      apb(1, `OFS_CONFIG, 32'h140, 0, 0, 0);
      edges(40);
      chk(n_rst, 0);
      apb(1, `OFS_CONTROL, 32'h20, 0, 0, 0);
      wt(2);
      chk({31'h0, low_power_rc_osc_enable}, 1);
      edges(40);
      chk(n_rst, 1);
      apb(0, `OFS_CONTROL, 0, 32'h30, 32'h30, 0);
      apb(0, `OFS_STATUS, 0, 1, 1, 0);
      $display("test soft mode done");
      apb(1, `OFS_IRQ_EN, 1, 0, 0, 0);
      wt(2);
      chk({31'h0, irq}, 1);
      apb(1, `OFS_IRQ_EN, 0, 0, 0, 0);
      wt(2);
      chk({31'h0, irq}, 0);
      apb(1, `OFS_IRQ_EN, 1, 0, 0, 0);
      apb(1, `OFS_IRQ_CLR, 1, 0, 0, 0);
      lfsr = nxt(lfsr);
      apb(1, `OFS_STATUS, lfsr | 32'h1, 0, 0, 0);
      wt(2);
      chk({31'h0, irq}, 0);
      apb(0, `OFS_STATUS, 0, 1, 0, 0);
      $display("test interrupt done");
      apb(1, `OFS_CONTROL, 0, 0, 0, 0);
      apb(1, `OFS_CONFIG, 32'h1C0, 0, 0, 0);
      pulse(1);
      edges(40);
      chk(n_wake, 1);
      chk(n_rst, 1);
      pulse(3);
      apb(0, `OFS_CONTROL, 0, 32'h8, 32'h8, 0);
      $display("test sleep wake done");
      apb(1, `OFS_CONFIG, 32'h0C0, 0, 0, 0);
      apb(1, `OFS_CONTROL, 32'h20, 0, 0, 0);
      apb(0, `OFS_CONTROL, 0, 32'h20, 0, 0);
      pulse(1);
      edges(40);
      chk(n_wake, 1);
      chk(n_rst, 1);
      pulse(3);
      pulse(2);
      apb(0, `OFS_CONTROL, 0, 32'h4, 32'h4, 0);
      pulse(3);
      $display("test run idle mode done");
      apb(1, `OFS_CONFIG, 32'h182, 0, 0, 0);
      pulse(4);
      pulse(0);
      wt(12);
      chk(n_rst, 2);
      apb(0, `OFS_STATUS, 0, 4, 4, 0);
      $display("test window done");
      apb(1, `OFS_CONFIG, 32'h040, 0, 0, 0);
      wt(2);
      chk({31'h0, low_power_rc_osc_enable}, 0);
      edges(40);
      chk(n_rst, 2);
      $display("test disabled mode done");
      wrap_up;
   end
endmodule // windowed_watchdog_timer_bench
`default_nettype wire
